// [boost_adaptive_voltage_config.v]
// Purpose: Holds the two boost configuration registers and derives the
//          gate drive code and the boost voltage target in control steps.
// Assumes: All inputs except rstn come from logic on the same 40 MHz clock.
//          rstn may come straight from a pin; it is released through two flops.
// Notes:   One control step is 0.125 V; a startup code count is 4 steps.
//          Adaptive off or a start reload beats every adjustment, and a jump
//          beats a single step, so a start always lands on the startup code.
`timescale 1ns/1ps
`include "boost_cfg_regs.vh"

module boost_adaptive_voltage_config (
  // Clock and reset
  input  wire        clock,
  input  wire        rstn,
  // Register port
  input  wire [7:0]  regAddr,
  input  wire        regWrite,
  input  wire [7:0]  regWriteData,
  output reg  [7:0]  regReadData,
  // Converter status from the power stage control
  input  wire        boostStart,
  input  wire        allClusterMode,
  input  wire        stepTick,
  input  wire        headroomLow,
  input  wire        headroomHigh,
  input  wire [15:0] brightness,
  // Outputs to the power stage
  output reg  [1:0]  gateDriveStrength,
  output reg  [7:0]  targetStep,
  output reg         adaptiveActive,
  output reg         jumpPulse
);

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  // Brightness rise needed for a jump
  function [15:0] jumpThreshold;
    input [1:0] code;
    begin
      case (code)
        2'h0:    jumpThreshold = `THR_10PCT;
        2'h1:    jumpThreshold = `THR_30PCT;
        2'h2:    jumpThreshold = `THR_50PCT;
        default: jumpThreshold = `THR_70PCT;
      endcase
    end
  endfunction

  // Steps added by a jump
  function [7:0] jumpSize;
    input [1:0] code;
    begin
      case (code)
        2'h0:    jumpSize = `JUMP_8_STEPS;
        2'h1:    jumpSize = `JUMP_16_STEPS;
        2'h2:    jumpSize = `JUMP_32_STEPS;
        default: jumpSize = `JUMP_64_STEPS;
      endcase
    end
  endfunction

  // Add with clamp at the top step
  function [7:0] addClamp;
    input [7:0] base;
    input [7:0] inc;
    reg   [8:0] sum;
    begin
      sum = {1'b0, base} + {1'b0, inc};
      if (sum > {1'b0, `MAX_STEP}) begin
        addClamp = `MAX_STEP;
      end else begin
        addClamp = sum[7:0];
      end
    end
  endfunction

  // --------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------
  reg        rstSync1;
  reg        rstSync2;

  // Asynchronous assert, two-stage synchronous release
  // Only the second flop feeds the logic, so a late release cannot split it
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end

  wire       resetN = rstSync2;

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  reg  [7:0] driveAdaptJump;
  reg  [5:0] startupCode;

  // Register writes
  always @(posedge clock or negedge resetN) begin
    if (!resetN) begin
      driveAdaptJump <= `RST_DRIVE_ADAPT_JUMP;
      startupCode    <= `RST_STARTUP_VOLTAGE;
    end else if (regWrite) begin
      if (regAddr == `ADDR_DRIVE_ADAPT_JUMP) begin
        driveAdaptJump <= regWriteData;
      end
      if (regAddr == `ADDR_STARTUP_VOLTAGE) begin
        startupCode <= regWriteData[`STARTUP_CODE_HI:`STARTUP_CODE_LO];
      end
    end
  end

  // Startup register as read back, reserved bits zero
  wire [7:0] startupRead = {`RESERVED_READ, startupCode};

  // Read mux; reserved bits and unmapped addresses read zero
  always @(posedge clock or negedge resetN) begin
    if (!resetN) begin
      regReadData <= `RST_READ_DATA;
    end else begin
      case (regAddr)
        `ADDR_DRIVE_ADAPT_JUMP: regReadData <= driveAdaptJump;
        `ADDR_STARTUP_VOLTAGE:  regReadData <= startupRead;
        default:                regReadData <= `UNMAPPED_READ;
      endcase
    end
  end

  // Field views
  wire       adaptEnable  = driveAdaptJump[`ADAPT_EN_BIT];
  wire       jumpEnable   = driveAdaptJump[`JUMP_EN_BIT];
  wire [1:0] thrCode      = driveAdaptJump[`JUMP_THR_HI:`JUMP_THR_LO];
  wire [1:0] incCode      = driveAdaptJump[`JUMP_INC_HI:`JUMP_INC_LO];
  // Code 63 lands on 252 steps, the 47.5 V top
  wire [7:0] startupStep  = {startupCode, 2'h0};
  wire       next_adaptive = adaptEnable & ~allClusterMode;

  // --------------------------------------------------------------------
  // Brightness tracking for jumps
  // --------------------------------------------------------------------
  reg  [15:0] brightRef;
  wire        brightRise  = brightness > brightRef;
  wire [15:0] brightDelta = brightness - brightRef;
  // Jump only while adaptive runs and jumps are allowed
  wire        jumpDue     = next_adaptive & jumpEnable & brightRise &
                            (brightDelta >= jumpThreshold(thrCode));

  // Reference follows falls at once and rises only on a jump or a start reload
  always @(posedge clock or negedge resetN) begin
    if (!resetN) begin
      brightRef <= `RST_BRIGHT_REF;
    end else if (boostStart || jumpDue || !brightRise) begin
      brightRef <= brightness;
    end
  end

  // --------------------------------------------------------------------
  // Target control
  // --------------------------------------------------------------------
  reg  [7:0] next_target;

  // Single-step requests from the headroom report
  wire       stepUp   = stepTick & headroomLow;
  wire       stepDown = stepTick & headroomHigh & (targetStep != `MIN_STEP);

  // Choose the next target step
  always @* begin
    next_target = targetStep;
    if (boostStart || !next_adaptive) begin
      next_target = startupStep;
    end else if (jumpDue) begin
      next_target = addClamp(targetStep, jumpSize(incCode));
    end else if (stepUp) begin
      next_target = addClamp(targetStep, `SINGLE_STEP);
    end else if (stepDown) begin
      next_target = targetStep - `SINGLE_STEP;
    end
  end

  // --------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------
  // Boost voltage target in control steps
  always @(posedge clock or negedge resetN) begin
    if (!resetN) begin
      targetStep <= `RST_TARGET_STEP;
    end else begin
      targetStep <= next_target;
    end
  end

  // Adaptive state seen by the power stage
  always @(posedge clock or negedge resetN) begin
    if (!resetN) begin
      adaptiveActive <= 1'b0;
    end else begin
      adaptiveActive <= next_adaptive;
    end
  end

  // One pulse per applied jump; a start reload suppresses it
  always @(posedge clock or negedge resetN) begin
    if (!resetN) begin
      jumpPulse <= 1'b0;
    end else begin
      jumpPulse <= jumpDue & ~boostStart;
    end
  end

  // Gate driver peak current code
  always @(posedge clock or negedge resetN) begin
    if (!resetN) begin
      gateDriveStrength <= `RST_GATE_DRIVE;
    end else begin
      gateDriveStrength <= driveAdaptJump[`GATE_DRIVE_HI:`GATE_DRIVE_LO];
    end
  end

endmodule // boost_adaptive_voltage_config

// [boost_cfg_regs.vh]
// Purpose: Register map, field positions and constants of the boost
//          voltage configuration block.
// Assumes: Included by bare name from the single design file.
// Notes:   Target voltage is held in control steps of 0.125 V above 16 V.
//
// Overview of operation
// - Two-bit code picks gate driver peak current
// - Adaptive off: hold target at startup code
// - Adaptive on: start at code, then follow LEDs
// - All outputs cluster mode forces adaptive off
// - Jump enable allows large jumps besides single steps
// - Jump after brightness rise of 10/30/50/70 percent
// - Jump adds 8, 16, 32 or 64 steps
// - Startup code means 16 V plus 0.5 V each
// - All-ones code is the 47.5 V maximum
`ifndef BOOST_CFG_REGS_VH
`define BOOST_CFG_REGS_VH

// ----------------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------------
`define ADDR_DRIVE_ADAPT_JUMP 8'h72
`define ADDR_STARTUP_VOLTAGE  8'h73
`define RST_DRIVE_ADAPT_JUMP  8'h00
`define RST_STARTUP_VOLTAGE   6'h00
`define RST_TARGET_STEP       8'h00
`define RST_GATE_DRIVE        2'h0
`define RST_BRIGHT_REF        16'h0000
`define RST_READ_DATA         8'h00
`define UNMAPPED_READ         8'h00
`define RESERVED_READ         2'h0

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define GATE_DRIVE_HI   7
`define GATE_DRIVE_LO   6
`define ADAPT_EN_BIT    5
`define JUMP_EN_BIT     4
`define JUMP_THR_HI     3
`define JUMP_THR_LO     2
`define JUMP_INC_HI     1
`define JUMP_INC_LO     0
`define STARTUP_CODE_HI 5
`define STARTUP_CODE_LO 0

// ----------------------------------------------------------------------
// Step arithmetic and brightness thresholds (16-bit full scale)
// ----------------------------------------------------------------------
`define STEPS_PER_CODE_SHIFT 2
`define MAX_STEP        8'hFC
`define MIN_STEP        8'h00
`define SINGLE_STEP     8'h01
`define THR_10PCT       16'h199A
`define THR_30PCT       16'h4CCD
`define THR_50PCT       16'h8000
`define THR_70PCT       16'hB333
`define JUMP_8_STEPS    8'h08
`define JUMP_16_STEPS   8'h10
`define JUMP_32_STEPS   8'h20
`define JUMP_64_STEPS   8'h40

`endif

// [boost_cfg_chk.sv]
// Purpose: Port checker for the boost configuration block
// Assumes: One clock domain, rstn active low
// Notes:   Shadows both registers from the write port
`timescale 1ns/1ps
module boost_cfg_chk (
  // Watched ports
  input wire       clock,
  input wire       rstn,
  input wire [7:0] regAddr,
  input wire       regWrite,
  input wire [7:0] regWriteData,
  input wire [7:0] regReadData,
  input wire       boostStart,
  input wire       allClusterMode,
  input wire [1:0] gateDriveStrength,
  input wire [7:0] targetStep,
  input wire       adaptiveActive,
  input wire       jumpPulse
);
  reg [7:0] s72;
  reg [5:0] s73;
  // Shadow copies of both registers
  always @(posedge clock or negedge rstn)
    if (!rstn) {s72, s73} <= 14'h0000;
    else if (regWrite && regAddr == 8'h72) s72 <= regWriteData;
    else if (regWrite && regAddr == 8'h73) s73 <= regWriteData[5:0];
  // Target after a jump, held at the top step
  function [7:0] bump(input [7:0] t, input [1:0] c);
    bump = ({1'b0, t} + (9'h008 << c) > 9'h0FC) ? 8'hFC : t + (8'h08 << c);
  endfunction
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence wr72; regWrite && regAddr == 8'h72; endsequence
  a_read_back: assert property (wr72 ##1 (!regWrite && regAddr == 8'h72)
    |=> regReadData == $past(regWriteData, 2)) else $error("read back wrong");
  a_gate_copy: assert property (!regWrite [*2] |-> gateDriveStrength == s72[7:6])
    else $error("drive code wrong");
  a_fixed_target: assert property ((!s72[5] && $stable(s73)) [*2]
    |-> targetStep == {s73, 2'b00}) else $error("fixed target wrong");
  a_start_reload: assert property (boostStart |=> targetStep == {$past(s73), 2'b00})
    else $error("start target wrong");
  a_cluster_off: assert property (allClusterMode |=> !adaptiveActive)
    else $error("adaptive in cluster");
  a_jump_gate: assert property (jumpPulse |-> $past(s72[5:4]) == 2'b11)
    else $error("jump not enabled");
  a_jump_size: assert property (jumpPulse
    |-> targetStep == bump($past(targetStep), $past(s72[1:0]))) else $error("jump size");
  a_target_max: assert property (targetStep <= 8'hFC)
    else $error("target above max");
  a_single_step: assert property (adaptiveActive && !jumpPulse && !$past(boostStart)
    |-> targetStep <= $past(targetStep) + 8'h01 && targetStep + 8'h01 >= $past(targetStep))
    else $error("target moved more than one step");
endmodule // boost_cfg_chk
bind boost_adaptive_voltage_config boost_cfg_chk boost_cfg_chk_i (
  .clock(clock), .rstn(rstn), .regAddr(regAddr), .regWrite(regWrite),
  .regWriteData(regWriteData), .regReadData(regReadData), .boostStart(boostStart),
  .allClusterMode(allClusterMode), .gateDriveStrength(gateDriveStrength),
  .targetStep(targetStep), .adaptiveActive(adaptiveActive), .jumpPulse(jumpPulse));

// [boost_stage_model.sv]
// Purpose: Power stage and LED string model
// Assumes: needStep is the step the highest string needs
// Notes:   Reports headroom each cycle, ticks every 4 cycles
`timescale 1ns/1ps
module boost_stage_model (
  // Clock and target
  input  wire       clock,
  input  wire [7:0] targetStep,
  input  wire [7:0] needStep,
  // Headroom report
  output reg        stepTick,
  output reg        headroomLow,
  output reg        headroomHigh
);
  reg [1:0] div = 2'h0;
  initial {stepTick, headroomLow, headroomHigh} = 3'h0;
  // Tick and compare target with string need
  always @(posedge clock) begin
    div <= div + 2'h1;
    stepTick <= (div == 2'h3);
    headroomLow <= targetStep < needStep;
    headroomHigh <= {1'b0, targetStep} > {1'b0, needStep} + 9'h004;
  end
endmodule // boost_stage_model

// [tb.sv]
// Purpose: Self-checking bench for the boost configuration block
// Assumes: Reads answer one cycle after the address
// Notes:   Read and jump results are checked from queues
`timescale 1ns/1ps
module tb;
  reg        clock, rstn, regWrite, boostStart, allClusterMode, rdReq, rdLate;
  reg [7:0]  regAddr, regWriteData, prevT, needStep, d;
  reg [15:0] brightness;
  wire [7:0] regReadData, targetStep;
  wire [1:0] gateDriveStrength;
  wire       stepTick, headroomLow, headroomHigh, adaptiveActive, jumpPulse;
  integer    badCount, checked, cycles, t, i;
  reg [7:0]  rq[$];
  reg [1:0]  jq[$];
  boost_adaptive_voltage_config boost_adaptive_voltage_config_i (
    .clock(clock), .rstn(rstn), .regAddr(regAddr), .regWrite(regWrite),
    .regWriteData(regWriteData), .regReadData(regReadData), .boostStart(boostStart),
    .allClusterMode(allClusterMode), .stepTick(stepTick), .headroomLow(headroomLow),
    .headroomHigh(headroomHigh), .brightness(brightness),
    .gateDriveStrength(gateDriveStrength), .targetStep(targetStep),
    .adaptiveActive(adaptiveActive), .jumpPulse(jumpPulse));
  boost_stage_model boost_stage_model_i (.clock(clock), .targetStep(targetStep),
    .needStep(needStep), .stepTick(stepTick), .headroomLow(headroomLow),
    .headroomHigh(headroomHigh));
  always #12.5 clock = ~clock;
  // Compare and count
  task chk(input [15:0] seen, input [15:0] want);
    begin
      checked = checked + 1;
      if (seen !== want) begin
        badCount = badCount + 1;
        $display("Error %0t seen %0h want %0h", $time, seen, want);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(negedge clock) {regAddr, regWriteData, regWrite} = {a, v, 1'b1};
      @(negedge clock) regWrite = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(negedge clock) {regAddr, rdReq} = {a, 1'b1};
      rq.push_back(e);
      @(negedge clock) rdReq = 1'b0;
    end
  endtask
  function [7:0] bump(input [7:0] p, input [1:0] c);
    bump = ({1'b0, p} + (9'h008 << c) > 9'h0FC) ? 8'hFC : p + (8'h08 << c);
  endfunction
  task endOfTest;
    begin
      $display("checked %0d bad %0d", checked, badCount);
      if (badCount == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Watcher: takes the oldest note when a result appears
  always @(posedge clock) begin
    rdLate <= rdReq;
    prevT <= targetStep;
    cycles = cycles + 1;
    if (rdLate) chk(regReadData, rq.pop_front());
    if (jumpPulse) chk(targetStep, jq.size() ? bump(prevT, jq.pop_front()) : 8'hXX);
    if (cycles > 2000) begin
      badCount = badCount + 1;
      endOfTest;
    end
  end
  // Driver
  initial begin
    {clock, rstn, regWrite, boostStart, allClusterMode, rdReq} = 6'h00;
    {regAddr, regWriteData, needStep, brightness} = 40'h0;
    {badCount, checked, cycles} = 0;
    t = $urandom(29987);
    repeat (4) @(negedge clock);
    rstn = 1'b1;
    repeat (3) @(negedge clock);
    rd(8'h72, 8'h00);
    rd(8'h73, 8'h00);
    d = 8'($urandom);
    wr(8'h72, d);
    rd(8'h72, d);
    wr(8'h73, 8'hFF);
    rd(8'h73, 8'h3F);
    wr(8'h74, d);
    rd(8'h74, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h72, {i[1:0], 6'h00});
      repeat (3) @(negedge clock);
      chk(gateDriveStrength, i[1:0]);
      if (i == 0) chk(targetStep, 8'hFC);
    end
    needStep = 8'hFF;
    for (i = 0; i < 16; i = i + 1) begin
      t = (65535 * (10 + 20 * i[1:0]) + 99) / 100;
      d = 8'($urandom);
      wr(8'h73, d);
      wr(8'h72, {4'h3, i[1:0], i[3:2]});
      @(negedge clock) {boostStart, brightness} = {1'b1, 16'h0000};
      @(negedge clock) boostStart = 1'b0;
      chk(targetStep, {8'h00, d[5:0], 2'h0});
      brightness = t[15:0] - 16'h0001;
      repeat (3) @(negedge clock);
      jq.push_back(i[3:2]);
      brightness = t[15:0];
      repeat (4) @(negedge clock);
    end
    for (i = 0; i < 2; i = i + 1) begin
      wr(8'h72, i ? 8'h30 : 8'h20);
      allClusterMode = i[0];
      @(negedge clock) brightness = 16'h0000;
      @(negedge clock) brightness = 16'hFFFF;
      repeat (3) @(negedge clock);
      chk(adaptiveActive, {15'h0, ~i[0]});
    end
    chk(16'(jq.size()), 16'h0000);
    endOfTest;
  end
endmodule // tb
